// ==== src/pmsc_pkg.sv ====
// Package for the supply control register bank: offsets, reset values and field positions.
`default_nettype none
package pmsc_pkg;
   // Register offsets.
   localparam logic [7:0] FAULT_MASK_ADDR   = 8'h02;
   localparam logic [7:0] SUPPLY_EN_ADDR    = 8'h03;
   localparam logic [7:0] CONV_MODE_ADDR    = 8'h04;

   // Values after reset and after undervoltage lockout, and the read value of unmapped offsets.
   localparam logic [7:0] FAULT_MASK_RESET  = 8'hC0;
   localparam logic [7:0] SUPPLY_EN_RESET   = 8'hFF;
   localparam logic [7:0] CONV_MODE_RESET   = 8'hB1;
   localparam logic [7:0] UNMAPPED_READ     = 8'hFF;

   // Bits that software may change; all others hold their reset value.
   localparam logic [7:0] FAULT_MASK_WMASK  = 8'hFE;
   localparam logic [7:0] SUPPLY_EN_WMASK   = 8'h3E;
   localparam logic [7:0] CONV_MODE_WMASK   = 8'hFF;

   // Field positions.
   localparam int BUCK_ONE_BIT      = 5;
   localparam int BUCK_TWO_BIT      = 4;
   localparam int BUCK_THREE_BIT    = 3;
   localparam int LINREG_TWO_BIT    = 2;
   localparam int LINREG_ONE_BIT    = 1;
   localparam int BUCK_TWO_PHASE_HI = 7;
   localparam int BUCK_TWO_PHASE_LO = 6;
   localparam int BUCK_THR_PHASE_HI = 5;
   localparam int BUCK_THR_PHASE_LO = 4;
   localparam int LOW_RIPPLE_BIT    = 3;
   localparam int FORCED_BUCK_TWO_BIT = 2;
   localparam int FORCED_BUCK_ONE_BIT = 1;
   localparam int FORCED_BUCK_THR_BIT = 0;

   // Phase delay of a converter relative to the reference converter.
   typedef enum logic [1:0] {
      PMSC_PHASE_ZERO    = 2'h0,
      PMSC_PHASE_QUARTER = 2'h1,
      PMSC_PHASE_HALF    = 2'h2,
      PMSC_PHASE_THREE_Q = 2'h3
   } pmsc_phase_t;
endpackage : pmsc_pkg
`default_nettype wire

// ==== src/pmsc_fault_if.sv ====
// Interface carrying fault flags, mask and supply state to the fault output gate.
`timescale 1ns/1ps
`default_nettype none
interface pmsc_fault_if;
   logic [7:1] flags;
   logic [7:1] mask;
   logic [5:1] enabled;
   logic       flag_read;
   logic       int_n;
   modport ctrl (output flags, output mask, output enabled, output flag_read, input int_n);
   modport gate (input flags, input mask, input enabled, input flag_read, output int_n);
endinterface : pmsc_fault_if
`default_nettype wire

// ==== src/pmsc_fault_gate.sv ====
// Fault output gate: masks, read blocking and the open fault/interrupt level.
`timescale 1ns/1ps
`default_nettype none
module pmsc_fault_gate
   import pmsc_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Fault carrier.
   pmsc_fault_if.gate f
);
   logic [7:1] blocked;
   logic [7:1] next_blocked;
   logic [7:1] raw;
   logic       int_n;
   logic       next_int_n;

   always_comb begin
      // A disabled supply cannot report a fault.
      raw = f.flags & {2'b11, f.enabled};
      // A read blocks what is active now; a bit unblocks once its flag clears.
      next_blocked = (blocked | (f.flag_read ? raw : 7'h00)) & raw;
      next_int_n = ~|(raw & ~f.mask & ~next_blocked);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blocked <= 7'h00;
         int_n   <= 1'b1;
      end else begin
         blocked <= next_blocked;
         int_n   <= next_int_n;
      end
   end

   assign f.int_n = int_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_masked_stays_quiet: assert property (((raw & ~f.mask) == 7'h00) |=> int_n)
      else $error("fault output asserted by a masked flag");
   a_unmasked_drives: assert property ((((raw & ~f.mask & ~blocked) != 7'h00) && !f.flag_read) |=> !int_n)
      else $error("unmasked fault did not reach the output");
   a_read_blocks_flags: assert property (f.flag_read |=> int_n)
      else $error("flags still drive the output after a flag read");
endmodule : pmsc_fault_gate
`default_nettype wire

// ==== src/pmsc_regs.sv ====
// Supply control register bank: fault mask, supply enables and converter mode/phase.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - A mask bit at one keeps its fault flag off the fault output.
// - Mask register at 02h, read/write, reset C0h, bits 7 to 1 mask flags.
// - Lockout reloads enables to all ones and mask, converter fields to defaults.
// - A supply runs only when its enable bit and its enable pin are high.
// - A low enable pin forces its enable bits back to one.
// - Supply-enable register at 03h, read/write, reset FFh, bits 5 to 1.
// - Host writes enable bits to zero or one; value holds until restored.
// - The shared linear-regulator pin re-arms both linear-regulator enable bits.
// - Converter register at 04h, reset B1h: phases, ripple, forced PWM bits.
// - Phase codes 00, 01, 10, 11 delay zero, quarter, half, three quarters.
// - Converter one is the phase reference and always has zero offset.
// - Bit 3 picks light-load mode: efficiency at zero, low ripple at one.
// - Forced PWM: bit 2 converter two, bit 1 converter one, bit 0 converter three.
// - Fault output combines unmasked flags of enabled supplies and flags 7 and 6.
// - Reading the flag register blocks the active flags from the fault output.
module pmsc_regs
   import pmsc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Register access from the serial engine.
   input  wire logic       reg_wr_stb,
   input  wire logic       reg_rd_stb,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   // Supervisor and enable pins.
   input  wire logic       undervoltage_lockout,
   input  wire logic       buck_one_enable_pin,
   input  wire logic       buck_two_enable_pin,
   input  wire logic       buck_three_enable_pin,
   input  wire logic       linear_regulator_enable_pin,
   // Fault flags and their read event.
   input  wire logic [7:1] power_good_fault_flags,
   input  wire logic       fault_flags_read,
   // Supply and converter controls.
   output var  logic [5:1] supply_on,
   output var  logic [1:0] buck_one_phase_select,
   output var  logic [1:0] buck_two_phase_select,
   output var  logic [1:0] buck_three_phase_select,
   output var  logic       low_ripple,
   output var  logic [2:0] forced_fixed_frequency,
   // Open fault/interrupt level, low while a fault shows.
   output var  logic       fault_int_n
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [7:0] fault_mask;
   logic [7:0] supply_enable_control;
   logic [7:0] converter_mode_phase;
   logic [7:0] next_fault_mask;
   logic [7:0] next_supply_enable_control;
   logic [7:0] next_converter_mode_phase;
   logic [7:0] next_reg_rdata;
   logic [5:1] next_supply_on;
   logic [5:1] pin_high;

   pmsc_fault_if fault_bus ();

   // Only writable bits take the new value; the rest are rebuilt from the reset pattern.
   function automatic logic [7:0] apply_write(input logic [7:0] old, input logic [7:0] wdata,
                                              input logic [7:0] wmask, input logic [7:0] rst_val);
      apply_write = (((old & ~wmask) | (wdata & wmask)) & wmask) | (rst_val & ~wmask);
   endfunction : apply_write

   ////////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      // Both linear regulators follow the single shared pin.
      pin_high = {buck_one_enable_pin, buck_two_enable_pin, buck_three_enable_pin,
                  linear_regulator_enable_pin, linear_regulator_enable_pin};
      next_fault_mask            = fault_mask;
      next_supply_enable_control = supply_enable_control;
      next_converter_mode_phase  = converter_mode_phase;
      if (reg_wr_stb) begin
         unique case (reg_addr)
            FAULT_MASK_ADDR: next_fault_mask =
               apply_write(fault_mask, reg_wdata, FAULT_MASK_WMASK, FAULT_MASK_RESET);
            SUPPLY_EN_ADDR: next_supply_enable_control =
               apply_write(supply_enable_control, reg_wdata, SUPPLY_EN_WMASK, SUPPLY_EN_RESET);
            CONV_MODE_ADDR: next_converter_mode_phase =
               apply_write(converter_mode_phase, reg_wdata, CONV_MODE_WMASK, CONV_MODE_RESET);
            default: ;
         endcase
      end
      // A low pin wins over a write in the same cycle, so the supply re-arms.
      next_supply_enable_control[5:1] = next_supply_enable_control[5:1] | ~pin_high;
      if (undervoltage_lockout) begin
         next_fault_mask            = FAULT_MASK_RESET;
         next_supply_enable_control = SUPPLY_EN_RESET;
         next_converter_mode_phase  = CONV_MODE_RESET;
      end
      next_supply_on = next_supply_enable_control[5:1] & pin_high;
      next_reg_rdata = reg_rdata;
      if (reg_rd_stb) begin
         unique case (reg_addr)
            FAULT_MASK_ADDR: next_reg_rdata = fault_mask;
            SUPPLY_EN_ADDR:  next_reg_rdata = supply_enable_control;
            CONV_MODE_ADDR:  next_reg_rdata = converter_mode_phase;
            default:         next_reg_rdata = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_mask            <= FAULT_MASK_RESET;
         supply_enable_control <= SUPPLY_EN_RESET;
         converter_mode_phase  <= CONV_MODE_RESET;
         reg_rdata             <= UNMAPPED_READ;
         supply_on             <= 5'h00;
      end else begin
         fault_mask            <= next_fault_mask;
         supply_enable_control <= next_supply_enable_control;
         converter_mode_phase  <= next_converter_mode_phase;
         reg_rdata             <= next_reg_rdata;
         supply_on             <= next_supply_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Converter controls are registered copies of the next register value, so they
   // change on the same edge as the register itself.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buck_one_phase_select   <= PMSC_PHASE_ZERO;
         buck_two_phase_select   <= CONV_MODE_RESET[BUCK_TWO_PHASE_HI:BUCK_TWO_PHASE_LO];
         buck_three_phase_select <= CONV_MODE_RESET[BUCK_THR_PHASE_HI:BUCK_THR_PHASE_LO];
         low_ripple              <= CONV_MODE_RESET[LOW_RIPPLE_BIT];
         forced_fixed_frequency  <= {CONV_MODE_RESET[FORCED_BUCK_THR_BIT], CONV_MODE_RESET[FORCED_BUCK_TWO_BIT],
                                     CONV_MODE_RESET[FORCED_BUCK_ONE_BIT]};
      end else begin
         buck_one_phase_select   <= PMSC_PHASE_ZERO;
         buck_two_phase_select   <= next_converter_mode_phase[BUCK_TWO_PHASE_HI:BUCK_TWO_PHASE_LO];
         buck_three_phase_select <= next_converter_mode_phase[BUCK_THR_PHASE_HI:BUCK_THR_PHASE_LO];
         low_ripple              <= next_converter_mode_phase[LOW_RIPPLE_BIT];
         // Output order is converter three, two, one.
         forced_fixed_frequency  <= {next_converter_mode_phase[FORCED_BUCK_THR_BIT],
                                     next_converter_mode_phase[FORCED_BUCK_TWO_BIT],
                                     next_converter_mode_phase[FORCED_BUCK_ONE_BIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   assign fault_bus.flags     = power_good_fault_flags;
   assign fault_bus.mask      = fault_mask[7:1];
   assign fault_bus.enabled   = supply_on;
   assign fault_bus.flag_read = fault_flags_read;
   assign fault_int_n         = fault_bus.int_n;

   pmsc_fault_gate u_fault_gate (
      .clk   (clk),
      .rst_b (rst_b),
      .f     (fault_bus.gate)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_lockout_enable_reload: assert property (undervoltage_lockout |=> supply_enable_control == 8'hFF)
      else $error("lockout did not reload the supply enables");
   a_lockout_field_reload: assert property (undervoltage_lockout |=>
      (fault_mask == 8'hC0) && (converter_mode_phase == 8'hB1))
      else $error("lockout did not reload mask and converter fields");
   a_pin_low_rearm: assert property (!buck_one_enable_pin |=> supply_enable_control[5] && !supply_on[5])
      else $error("low pin did not re-arm its enable bit");
   a_shared_pin_rearm: assert property (!linear_regulator_enable_pin |=>
      (supply_enable_control[2:1] == 2'b11) && (supply_on[2:1] == 2'b00))
      else $error("shared pin did not re-arm both linear regulators");
   a_supply_and_gate: assert property (rst_b |=>
      supply_on[3] == ($past(buck_three_enable_pin) && supply_enable_control[3]))
      else $error("supply state is not enable bit and pin");
   a_enable_write_held: assert property ((reg_wr_stb && reg_addr == 8'h03 && !undervoltage_lockout &&
      buck_one_enable_pin && buck_two_enable_pin && buck_three_enable_pin && linear_regulator_enable_pin)
      |=> supply_enable_control == (($past(reg_wdata) & 8'h3E) | 8'hC1))
      else $error("written enable value not stored");
   a_unused_bits_fixed: assert property ((supply_enable_control[7:6] == 2'b11) && supply_enable_control[0]
      && !fault_mask[0])
      else $error("unassigned bit left its default");
   a_phase_fields: assert property ((buck_two_phase_select == converter_mode_phase[7:6]) &&
      (buck_three_phase_select == converter_mode_phase[5:4]) && (buck_one_phase_select == 2'b00))
      else $error("phase outputs do not follow the register");
   a_mode_bits_map: assert property ((forced_fixed_frequency == {converter_mode_phase[0],
      converter_mode_phase[2], converter_mode_phase[1]}) && (low_ripple == converter_mode_phase[3]))
      else $error("forced PWM or ripple mapping wrong");
   a_mask_write_read: assert property ((reg_wr_stb && reg_addr == 8'h02 && !undervoltage_lockout)
      |=> fault_mask == ($past(reg_wdata) & 8'hFE))
      else $error("mask write not stored");

   // Read data is registered, so each read-back check looks one edge after the strobe.
   a_mask_read_back: assert property ((reg_rd_stb && reg_addr == 8'h02)
      |=> reg_rdata == $past(fault_mask))
      else $error("mask read returned the wrong value");
   a_enable_read_back: assert property ((reg_rd_stb && reg_addr == 8'h03)
      |=> reg_rdata == $past(supply_enable_control))
      else $error("enable read returned the wrong value");
   a_conv_read_back: assert property ((reg_rd_stb && reg_addr == 8'h04)
      |=> reg_rdata == $past(converter_mode_phase))
      else $error("converter read returned the wrong value");
   a_conv_write_held: assert property ((reg_wr_stb && reg_addr == 8'h04 && !undervoltage_lockout)
      |=> converter_mode_phase == $past(reg_wdata))
      else $error("converter write not stored");
   a_pin_two_rearm: assert property (!buck_two_enable_pin
      |=> supply_enable_control[4] && !supply_on[4])
      else $error("low pin did not re-arm the second converter enable");
   a_pin_three_rearm: assert property (!buck_three_enable_pin
      |=> supply_enable_control[3] && !supply_on[3])
      else $error("low pin did not re-arm the third converter enable");
   a_lockout_supply_state: assert property (undervoltage_lockout
      |=> supply_on == {$past(buck_one_enable_pin), $past(buck_two_enable_pin), $past(buck_three_enable_pin),
      {2{$past(linear_regulator_enable_pin)}}})
      else $error("supplies do not follow their pins after lockout");
   a_fault_level_idle: assert property ((supply_on == 5'h00 && power_good_fault_flags[7:6] == 2'b00)
      |=> fault_int_n)
      else $error("fault output asserted with every supply off");
   a_shared_pin_on: assert property ((linear_regulator_enable_pin && supply_enable_control[2:1] == 2'b11 &&
      !undervoltage_lockout && !reg_wr_stb) |=> supply_on[2:1] == 2'b11)
      else $error("linear regulators did not turn on together");
endmodule : pmsc_regs
`default_nettype wire

// ==== verification/pmsc_host_model.sv ====
// Host model: hands register writes and reads to the bank as the serial engine would.
`timescale 1ns/1ps
`default_nettype none
module pmsc_host_model (
   // Clock.
   input  wire logic       clk,
   // Register access.
   output var  logic       reg_wr_stb,
   output var  logic       reg_rd_stb,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr_stb = 1'b0;
      reg_rd_stb = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
   end

   // Any byte goes to any bit; the bank decides what it keeps.
   // Released lines show the inverse so that a stale value is never mistaken for a live one.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr_stb <= 1'b1;
      reg_addr   <= a;
      reg_wdata  <= d;
      @(posedge clk);
      reg_wr_stb <= 1'b0;
      reg_addr   <= ~a;
      reg_wdata  <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd_stb <= 1'b1;
      reg_addr   <= a;
      @(posedge clk);
      reg_rd_stb <= 1'b0;
      reg_addr   <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : pmsc_host_model
`default_nettype wire

// ==== verification/pmic_supply_control_regs_tb_top.sv ====
// Testbench for the supply control register bank.
`timescale 1ns/1ps
`default_nettype none
module pmic_supply_control_regs_tb_top;
   import pmsc_pkg::*;
   logic       clk, rst_b, lockout, p1, p2, p3, pl, ffr, wr_stb, rd_stb, low_ripple, fault_int_n;
   logic [7:0] addr, wdata, rdata, v;
   logic [7:1] flags;
   logic [5:1] supply_on;
   logic [1:0] ph1, ph2, ph3;
   logic [2:0] ffq;
   int         mismatches = 0;
   int         n_tests = 0;

   pmsc_host_model host_u (.clk(clk), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata));
   pmsc_regs dut_u (.clk(clk), .rst_b(rst_b), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .undervoltage_lockout(lockout),
      .buck_one_enable_pin(p1), .buck_two_enable_pin(p2), .buck_three_enable_pin(p3),
      .linear_regulator_enable_pin(pl), .power_good_fault_flags(flags), .fault_flags_read(ffr),
      .supply_on(supply_on), .buck_one_phase_select(ph1), .buck_two_phase_select(ph2),
      .buck_three_phase_select(ph3), .low_ripple(low_ripple), .forced_fixed_frequency(ffq),
      .fault_int_n(fault_int_n));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic wrap_up();
      $display("Mismatches %0d, checks %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(a, d);
      chk(d, exp);
   endtask : rdchk

   // The fault level follows its cause within one cycle; three edges leave margin for the read block.
   // The task ends on a rising edge so that the caller's next drive lands on that edge.
   task automatic int_is(input logic exp);
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, fault_int_n}, {7'h00, exp});
      @(posedge clk);
   endtask : int_is

   initial begin
      rst_b = 1'b0;
      lockout = 1'b0;
      {p1, p2, p3, pl} = 4'hF;
      flags = 7'h00;
      ffr   = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(FAULT_MASK_ADDR, 8'hC0);
      rdchk(SUPPLY_EN_ADDR, 8'hFF);
      rdchk(CONV_MODE_ADDR, 8'hB1);
      rdchk(8'h05, 8'hFF);
      chk({ph2, ph3, ph1, low_ripple, 1'b0}, 8'hB0);
      chk({5'h00, ffq}, 8'h04);
      chk({3'h0, supply_on}, 8'h1F);
      chk({7'h00, fault_int_n}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         v = {i[1:0], 2'(3 - i), i[0], ~i[0], i[1], i[0]};
         host_u.wr(CONV_MODE_ADDR, v);
         rdchk(CONV_MODE_ADDR, v);
         chk({ph2, ph3, ph1, low_ripple, 1'b0}, {v[7:4], 2'b00, v[3], 1'b0});
         chk({5'h00, ffq}, {5'h00, v[0], v[2], v[1]});
      end
      host_u.wr(SUPPLY_EN_ADDR, 8'h00);
      rdchk(SUPPLY_EN_ADDR, 8'hC1);
      chk({3'h0, supply_on}, 8'h00);
      host_u.wr(FAULT_MASK_ADDR, 8'hFF);
      rdchk(FAULT_MASK_ADDR, 8'hFE);
      @(posedge clk);
      p1 <= 1'b0;
      pl <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({3'h0, supply_on}, 8'h00);
      rdchk(SUPPLY_EN_ADDR, 8'hE7);
      @(posedge clk);
      p1 <= 1'b1;
      pl <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({3'h0, supply_on}, 8'h13);
      // Buck one stays off so that its flag must not reach the fault level.
      host_u.wr(SUPPLY_EN_ADDR, 8'hDF);
      host_u.wr(FAULT_MASK_ADDR, 8'h00);
      @(posedge clk);
      flags[5] <= 1'b1;
      int_is(1'b1);
      flags[7] <= 1'b1;
      int_is(1'b0);
      host_u.wr(FAULT_MASK_ADDR, 8'h80);
      int_is(1'b1);
      host_u.wr(FAULT_MASK_ADDR, 8'h00);
      int_is(1'b0);
      ffr <= 1'b1;
      @(posedge clk);
      ffr <= 1'b0;
      int_is(1'b1);
      flags[7] <= 1'b0;
      @(posedge clk);
      flags[7] <= 1'b1;
      int_is(1'b0);
      flags <= 7'h00;
      host_u.wr(SUPPLY_EN_ADDR, 8'h00);
      host_u.wr(CONV_MODE_ADDR, 8'h00);
      host_u.wr(FAULT_MASK_ADDR, 8'h3E);
      lockout <= 1'b1;
      repeat (2) @(posedge clk);
      lockout <= 1'b0;
      rdchk(FAULT_MASK_ADDR, 8'hC0);
      rdchk(SUPPLY_EN_ADDR, 8'hFF);
      rdchk(CONV_MODE_ADDR, 8'hB1);
      chk({3'h0, supply_on}, 8'h1F);
      wrap_up();
   end

   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
endmodule : pmic_supply_control_regs_tb_top
`default_nettype wire
